/* hdl/eld_top.sv */
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
// LPI assert and detect with transmit and receive line sequencing
module eld_top #(
   parameter logic [7:0]  P_LPI_DATA  = eld_pkg::LPI_DATA,
   parameter logic [7:0]  P_IDLE_DATA = eld_pkg::IDLE_DATA,
   parameter logic [15:0] P_WAKE_RST  = eld_pkg::WAKE_RST,
   parameter int         P_TS_CYC    = eld_pkg::TS_CYC,
   parameter int         P_TQ_CYC    = eld_pkg::TQ_CYC,
   parameter int         P_TR_CYC    = eld_pkg::TR_CYC,
   parameter int         P_TW_CYC    = eld_pkg::TW_CYC
) (
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   // APB slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // LPI client
   input  wire logic        i_lpi_req,
   output logic             o_lpi_ind,
   // MAC transmit side
   input  wire logic [7:0]  i_mac_txd,
   input  wire logic        i_mac_tx_en,
   input  wire logic        i_mac_tx_er,
   output logic             o_mac_crs,
   // MAC receive side
   output logic [7:0]       o_mac_rxd,
   output logic             o_mac_rx_dv,
   output logic             o_mac_rx_er,
   // Transmit xMII
   output logic [7:0]       o_xmii_txd,
   output logic             o_xmii_tx_en,
   output logic             o_xmii_tx_er,
   // Receive xMII from the line receiver
   input  wire logic [7:0]  i_xmii_rxd,
   input  wire logic        i_xmii_rx_dv,
   input  wire logic        i_xmii_rx_er,
   // Line events from the partner
   input  wire logic        i_line_rx_sleep,
   input  wire logic        i_line_rx_wake,
   // Line signalling state
   output logic [2:0]       o_line_tx_mode,
   output logic             o_line_tx_off,
   output logic             o_line_rx_pwrdn
);

   localparam int CW = eld_pkg::CNT_W;

   // Assert LPI pattern test, shared by both directions
   function automatic logic is_lpi(
      input logic       en,
      input logic       er,
      input logic [7:0] d
   );
      is_lpi = !en && er && (d == P_LPI_DATA);
   endfunction

   logic                  gbt_r;        // Wait for remote sleep
   logic [15:0]           wake_r;       // Carrier release delay
   logic                  lpi_act_r;    // Assert LPI being sent
   logic                  lpi_act_nxt;  // Next of the above
   logic                  wake_zero;    // Carrier delay expired
   logic                  rmt_slept_r;  // Partner sent sleep
   logic                  rx_lpi_r;     // Receiver in LPI
   eld_pkg::eld_txst_type tx_st_r;      // Line transmit state
   eld_pkg::eld_txst_type tx_nxt;       // Its next value
   logic                  seq_zero;     // Line timer expired
   logic                  seq_load;     // Line timer reload
   logic [CW-1:0]         seq_val;      // Line timer value
   logic                  tx_lpi_seen;  // LPI on transmit xMII
   logic [7:0]            rxd_int;      // Receive xMII as seen
   logic                  rx_dv_int;
   logic                  rx_er_int;
   logic                  rx_is_lpi;    // Receive carries LPI
   logic                  wr_en;        // APB write strobe
   logic                  setup;        // APB setup phase

   // APB phase decode
   assign setup = i_psel && !i_penable;
   assign wr_en = i_psel && i_penable && o_pready && i_pwrite;

   // Answer one cycle after setup, flag unmapped addresses
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= '0;
      end
      else
      begin
         o_pready  <= setup;
         o_pslverr <= 1'b0;
         o_prdata  <= '0;
         if (setup)
         begin
            unique case (i_paddr)
               eld_pkg::ADDR_CTRL:
               begin
                  o_prdata[eld_pkg::CTRL_GBT_BIT] <= gbt_r;
               end
               eld_pkg::ADDR_WAKE:
               begin
                  o_prdata[eld_pkg::WAKE_W-1:0] <= wake_r;
               end
               eld_pkg::ADDR_STAT:
               begin
                  o_prdata[eld_pkg::STAT_TXST_LSB +: 3] <= tx_st_r;
                  o_prdata[eld_pkg::STAT_RXLPI_BIT]     <= rx_lpi_r;
                  o_prdata[eld_pkg::STAT_IND_BIT]       <= o_lpi_ind;
                  o_prdata[eld_pkg::STAT_CRS_BIT]       <= o_mac_crs;
                  o_prdata[eld_pkg::STAT_ACT_BIT]       <= lpi_act_r;
               end
               default:
               begin
                  o_pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

   // Control and wake delay registers
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         gbt_r  <= eld_pkg::CTRL_GBT_RST;
         wake_r <= P_WAKE_RST;
      end
      else if (wr_en)
      begin
         // Mode select for the quiet condition
         if (i_paddr == eld_pkg::ADDR_CTRL)
         begin
            gbt_r <= i_pwdata[eld_pkg::CTRL_GBT_BIT];
         end
         if (i_paddr == eld_pkg::ADDR_WAKE)
         begin
            wake_r <= i_pwdata[eld_pkg::WAKE_W-1:0];
         end
      end
   end

   // wait for a frame in flight to end first
   assign lpi_act_nxt = i_lpi_req && (lpi_act_r || !i_mac_tx_en);

   // Transmit xMII mux, registered
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         lpi_act_r    <= 1'b0;
         o_xmii_txd   <= P_IDLE_DATA;
         o_xmii_tx_en <= 1'b0;
         o_xmii_tx_er <= 1'b0;
      end
      else
      begin
         lpi_act_r <= lpi_act_nxt;
         if (lpi_act_nxt)
         begin
            o_xmii_txd   <= P_LPI_DATA;
            o_xmii_tx_en <= 1'b0;
            o_xmii_tx_er <= 1'b1;
         end
         else
         begin
            o_xmii_txd   <= i_mac_txd;
            o_xmii_tx_en <= i_mac_tx_en;
            o_xmii_tx_er <= i_mac_tx_er;
         end
      end
   end

   // delay reloads while requested, runs once released
   eld_cnt #(
      .W (eld_pkg::WAKE_W)
   ) u_wake_cnt (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_load   (i_lpi_req),
      .i_val    (wake_r),
      .o_zero   (wake_zero)
   );

   // Carrier toward the MAC
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_mac_crs <= 1'b0;
      end
      else
      begin
         // on with request, off after the delay
         o_mac_crs <= i_lpi_req || !wake_zero;
      end
   end

   // line side watches its own transmit xMII
   assign tx_lpi_seen = is_lpi(o_xmii_tx_en, o_xmii_tx_er, o_xmii_txd);

   // Line transmit sequencing
   always_comb
   begin
      tx_nxt = tx_st_r;
      unique case (tx_st_r)
         eld_pkg::TX_NORMAL:
         begin
            if (tx_lpi_seen)
            begin
               tx_nxt = eld_pkg::TX_SLEEP;
            end
         end
         eld_pkg::TX_SLEEP:
         begin
            if (!tx_lpi_seen)
            begin
               tx_nxt = eld_pkg::TX_WAKE;
            end
            // quiet now, or after partner sleep
            else if (seq_zero)
            begin
               tx_nxt = (gbt_r && !rmt_slept_r) ? eld_pkg::TX_WAIT_RMT
                                                : eld_pkg::TX_QUIET;
            end
         end
         eld_pkg::TX_WAIT_RMT:
         begin
            // LPI still passed on while powered
            if (!tx_lpi_seen)
            begin
               tx_nxt = eld_pkg::TX_WAKE;
            end
            else if (rmt_slept_r)
            begin
               tx_nxt = eld_pkg::TX_QUIET;
            end
         end
         eld_pkg::TX_QUIET:
         begin
            if (!tx_lpi_seen)
            begin
               tx_nxt = eld_pkg::TX_WAKE;
            end
            else if (seq_zero)
            begin
               tx_nxt = eld_pkg::TX_REFRESH;
            end
         end
         eld_pkg::TX_REFRESH:
         begin
            if (!tx_lpi_seen)
            begin
               tx_nxt = eld_pkg::TX_WAKE;
            end
            else if (seq_zero)
            begin
               tx_nxt = eld_pkg::TX_QUIET;
            end
         end
         eld_pkg::TX_WAKE:
         begin
            if (seq_zero)
            begin
               tx_nxt = eld_pkg::TX_NORMAL;
            end
         end
      endcase
   end

   // Timer reload on every state change
   assign seq_load = (tx_nxt != tx_st_r);

   // Duration of the state being entered
   always_comb
   begin
      seq_val = '0;
      unique case (tx_nxt)
         eld_pkg::TX_SLEEP:   seq_val = CW'(P_TS_CYC);
         eld_pkg::TX_QUIET:   seq_val = CW'(P_TQ_CYC);
         eld_pkg::TX_REFRESH: seq_val = CW'(P_TR_CYC);
         eld_pkg::TX_WAKE:    seq_val = CW'(P_TW_CYC);
         default:    seq_val = '0;
      endcase
   end

   // Line timer
   eld_cnt #(
      .W (CW)
   ) u_seq_cnt (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_load   (seq_load),
      .i_val    (seq_val),
      .o_zero   (seq_zero)
   );

   // State and line signalling outputs
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         tx_st_r        <= eld_pkg::TX_NORMAL;
         o_line_tx_mode <= '0;
         o_line_tx_off  <= 1'b0;
      end
      else
      begin
         tx_st_r        <= tx_nxt;
         o_line_tx_mode <= tx_nxt;
         o_line_tx_off  <= (tx_nxt == eld_pkg::TX_QUIET);
      end
   end

   // Partner sleep memory, set wins over clear
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rmt_slept_r <= 1'b0;
      end
      else if (i_line_rx_sleep)
      begin
         rmt_slept_r <= 1'b1;
      end
      else if (tx_st_r == eld_pkg::TX_NORMAL || i_line_rx_wake)
      begin
         rmt_slept_r <= 1'b0;
      end
   end

   // Receiver LPI state and power-down
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rx_lpi_r        <= 1'b0;
         o_line_rx_pwrdn <= 1'b0;
      end
      else if (i_line_rx_sleep)
      begin
         rx_lpi_r        <= 1'b1;
         o_line_rx_pwrdn <= 1'b1;
      end
      else if (i_line_rx_wake)
      begin
         rx_lpi_r        <= 1'b0;
         o_line_rx_pwrdn <= 1'b0;
      end
   end

   // Receive xMII as presented to the detect function
   assign rxd_int   = rx_lpi_r ? P_LPI_DATA : i_xmii_rxd;
   assign rx_dv_int = rx_lpi_r ? 1'b0 : i_xmii_rx_dv;
   assign rx_er_int = rx_lpi_r ? 1'b1 : i_xmii_rx_er;
   assign rx_is_lpi = is_lpi(rx_dv_int, rx_er_int, rxd_int);

   // Detect function toward MAC and client
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_lpi_ind   <= 1'b0;
         o_mac_rxd   <= P_IDLE_DATA;
         o_mac_rx_dv <= 1'b0;
         o_mac_rx_er <= 1'b0;
      end
      else if (rx_is_lpi)
      begin
         o_lpi_ind   <= 1'b1;
         o_mac_rxd   <= P_IDLE_DATA;
         o_mac_rx_dv <= 1'b0;
         o_mac_rx_er <= 1'b0;
      end
      else
      begin
         o_lpi_ind   <= 1'b0;
         o_mac_rxd   <= rxd_int;
         o_mac_rx_dv <= rx_dv_int;
         o_mac_rx_er <= rx_er_int;
      end
   end

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   a_tx_pass: assert property (
      !i_lpi_req |=> o_xmii_tx_en == $past(i_mac_tx_en)
                     && o_xmii_txd == $past(i_mac_txd))
      else $error("MAC transmit not passed through");

   a_lpi_drive: assert property (
      i_lpi_req && !i_mac_tx_en |=> o_xmii_tx_er && !o_xmii_tx_en
                                    && o_xmii_txd == P_LPI_DATA)
      else $error("Assert LPI not driven");

   a_crs_on: assert property (
      i_lpi_req |=> o_mac_crs)
      else $error("Carrier absent during request");

   a_crs_hold: assert property (
      $fell(i_lpi_req) && wake_r > 16'h0002 |=> o_mac_crs [*2])
      else $error("Carrier released before wake delay");

   a_wake_write: assert property (
      wr_en && i_paddr == eld_pkg::ADDR_WAKE
      |=> wake_r == $past(i_pwdata[15:0]))
      else $error("Wake delay not written");

   a_rx_pass: assert property (
      !rx_is_lpi |=> o_mac_rx_dv == $past(rx_dv_int) && !o_lpi_ind)
      else $error("Receive not forwarded");

   a_rx_idle: assert property (
      $rose(o_lpi_ind) |-> !o_mac_rx_dv && !o_mac_rx_er)
      else $error("Non idle during LPI indication");

   a_rx_exit: assert property (
      rx_lpi_r && i_line_rx_wake && !i_line_rx_sleep ##1 !rx_is_lpi
      |=> !o_lpi_ind)
      else $error("Indication not dropped");

   a_sleep_start: assert property (
      tx_st_r == eld_pkg::TX_NORMAL && tx_lpi_seen
      |=> tx_st_r == eld_pkg::TX_SLEEP)
      else $error("Sleep not started");

   a_gbt_wait: assert property (
      tx_st_r == eld_pkg::TX_WAIT_RMT && !rmt_slept_r
      |=> tx_st_r != eld_pkg::TX_QUIET)
      else $error("Quiet before remote sleep");

   a_rx_sleep: assert property (
      i_line_rx_sleep |=> rx_lpi_r ##1 o_lpi_ind)
      else $error("Remote sleep not presented");

endmodule

/* hdl/eld_pkg.sv */
// What this block does
// - Request low: pass MAC transmit unchanged.
// - Request high: drive Assert LPI, not idle.
// - Request high: carrier shown present to MAC.
// - Request low: resume normal interframe at once.
// - Hold carrier for wake delay, then release.
// - Wake delay default per PHY, software adjustable.
// - Non-LPI receive encodings forwarded to MAC.
// - Entering receive LPI: idle to MAC, indicate.
// - Leaving receive LPI: drop indication, decode normally.
// - Transmit LPI start: send sleep to partner.
// - Most PHY types go quiet after sleep.
// - Gigabit copper: quiet only after remote sleep too.
// - LPI still conveyed when partner declines.
// - Quiet and refresh repeat until idle returns.
// - Idle returns: send wake for fixed time.
// - Entry or exit never drops a frame.
// - Remote sleep seen: present Assert LPI, power down.
// - Remote wake seen: return receive to idle.
package eld_pkg;

   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_WAKE = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;

   // Field positions
   localparam int CTRL_GBT_BIT   = 0;
   localparam int WAKE_W         = 16;
   localparam int STAT_TXST_LSB  = 0;
   localparam int STAT_RXLPI_BIT = 4;
   localparam int STAT_IND_BIT   = 5;
   localparam int STAT_CRS_BIT   = 6;
   localparam int STAT_ACT_BIT   = 7;

   // Reset values
   localparam logic        CTRL_GBT_RST = 1'b0;
   localparam logic [15:0] WAKE_RST     = 16'h0400;

   // Clock rate and line timing in microseconds
   localparam int CLK_MHZ = 25;
   localparam int TS_US   = 200;
   localparam int TQ_US   = 20000;
   localparam int TR_US   = 200;
   localparam int TW_US   = 20;

   // Line timing in clock cycles
   localparam int TS_CYC = TS_US * CLK_MHZ;
   localparam int TQ_CYC = TQ_US * CLK_MHZ;
   localparam int TR_CYC = TR_US * CLK_MHZ;
   localparam int TW_CYC = TW_US * CLK_MHZ;
   localparam int CNT_W  = 20;

   // Byte-wide xMII encodings
   localparam logic [7:0] LPI_DATA = 8'h01;
   localparam logic [7:0] IDLE_DATA = 8'h00;

   // Line signalling of the transmitter
   typedef enum logic [2:0] {
      TX_NORMAL,
      TX_SLEEP,
      TX_WAIT_RMT,
      TX_QUIET,
      TX_REFRESH,
      TX_WAKE
   } eld_txst_type;

endpackage

/* hdl/eld_cnt.sv */
`timescale 1ns/1ns
// Loadable down-counter that stops at zero
module eld_cnt #(
   parameter int W = 20
) (
   input  wire logic         i_clk,
   input  wire logic         i_resetn,
   input  wire logic         i_load,
   input  wire logic [W-1:0] i_val,
   output logic              o_zero
);

   logic [W-1:0] cnt_r;   // Remaining count

   // Load wins, otherwise count toward zero
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         cnt_r <= '0;
      end
      else if (i_load)
      begin
         cnt_r <= i_val;
      end
      else if (cnt_r != '0)
      begin
         cnt_r <= cnt_r - W'(1);
      end
   end

   // Expiry flag
   assign o_zero = (cnt_r == '0);

endmodule

/* verif/eld_phy_model.sv */
`timescale 1ns/1ns
// Far-end partner as seen through our line receiver and receive xMII
module eld_phy_model (
   input  wire logic       i_clk,
   input  wire logic       i_resetn,
   input  wire logic       i_sleep_cmd,  // Partner starts low power idle
   input  wire logic       i_wake_cmd,   // Partner ends low power idle
   input  wire logic [7:0] i_rxd,        // Frame byte to deliver
   input  wire logic       i_rx_dv,      // Frame byte valid
   output logic            o_line_rx_sleep,
   output logic            o_line_rx_wake,
   output logic [7:0]      o_xmii_rxd,
   output logic            o_xmii_rx_dv,
   output logic            o_xmii_rx_er
);
   logic lpi_r;  // Partner is in low power idle

   // Line events, the commands registered one cycle later
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_line_rx_sleep <= 1'b0;
         o_line_rx_wake  <= 1'b0;
      end
      else
      begin
         o_line_rx_sleep <= i_sleep_cmd;
         o_line_rx_wake  <= i_wake_cmd;
      end
   end

   // Partner state, sleep wins over wake
   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         lpi_r <= 1'b0;
      else if (i_sleep_cmd)
         lpi_r <= 1'b1;
      else if (i_wake_cmd)
         lpi_r <= 1'b0;
   end

   always_comb
   begin
      if (lpi_r)
      begin
         o_xmii_rxd   = eld_pkg::LPI_DATA;
         o_xmii_rx_dv = 1'b0;
         o_xmii_rx_er = 1'b1;
      end
      else
      begin
         o_xmii_rxd   = i_rx_dv ? i_rxd : eld_pkg::IDLE_DATA;
         o_xmii_rx_dv = i_rx_dv;
         o_xmii_rx_er = 1'b0;
      end
   end
endmodule

/* verif/test_eld_top.sv */
`timescale 1ns/1ns
// Self-checking bench for the LPI assert and detect block
module test_eld_top;
   localparam int TS = 8;   // Shortened sleep time
   localparam int TQ = 20;  // Shortened quiet time
   localparam int TR = 6;   // Shortened refresh time
   localparam int TW = 5;   // Shortened wake time
   logic        i_clk, i_resetn, psel, penable, pwrite, pready, pslverr, e;
   logic        lpi_req, lpi_ind, tx_en, tx_er, crs, m_dv, m_er, x_en, x_er;
   logic        rx_dv, x_dv, x_er_in, slp, wak, l_slp, l_wak, x_off, pwrdn;
   logic [7:0]  paddr, txd, rxd, m_rxd, x_txd, x_rxd;
   logic [2:0]  mode;
   logic [31:0] pwdata, prdata, q;
   int          errors, num_checks, n, t;

   // Design under test with short line timing
   eld_top #(.P_TS_CYC(TS), .P_TQ_CYC(TQ), .P_TR_CYC(TR), .P_TW_CYC(TW)) uut (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_lpi_req(lpi_req),
      .o_lpi_ind(lpi_ind), .i_mac_txd(txd), .i_mac_tx_en(tx_en),
      .i_mac_tx_er(tx_er), .o_mac_crs(crs), .o_mac_rxd(m_rxd),
      .o_mac_rx_dv(m_dv), .o_mac_rx_er(m_er), .o_xmii_txd(x_txd),
      .o_xmii_tx_en(x_en), .o_xmii_tx_er(x_er), .i_xmii_rxd(x_rxd),
      .i_xmii_rx_dv(x_dv), .i_xmii_rx_er(x_er_in), .i_line_rx_sleep(l_slp),
      .i_line_rx_wake(l_wak), .o_line_tx_mode(mode), .o_line_tx_off(x_off),
      .o_line_rx_pwrdn(pwrdn));

   // Far end of the line
   eld_phy_model partner (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_sleep_cmd(slp), .i_wake_cmd(wak),
      .i_rxd(rxd), .i_rx_dv(rx_dv), .o_line_rx_sleep(l_slp),
      .o_line_rx_wake(l_wak), .o_xmii_rxd(x_rxd), .o_xmii_rx_dv(x_dv),
      .o_xmii_rx_er(x_er_in));

   // Verdict and end of run
   task end_of_test;
      if (errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Counted compare
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer, result in q and e
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge i_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge i_clk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      q = prdata;
      e = pslverr;
      chk(32'(k < 20), 32'h1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Wait for tx mode (0), carrier (1) or indication (2) to reach v
   task wait_on(input int w, input logic [2:0] v, input int lim);
      logic [2:0] g;
      n = 0;
      do
      begin
         @(posedge i_clk);
         n++;
         g = (w == 0) ? mode : (w == 1) ? {2'b0, crs} : {2'b0, lpi_ind};
      end
      while (g !== v && n < lim);
      chk(32'(g), 32'(v));
   endtask

   // Clock
   initial
   begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end

   // Hang guard
   initial
   begin
      #(40 * 6000);
      errors++;
      end_of_test;
   end

   // Main sequence
   initial
   begin
      errors = 0;
      num_checks = 0;
      {psel, penable, pwrite, lpi_req, tx_en, tx_er, rx_dv, slp, wak} = '0;
      {paddr, txd, rxd, pwdata} = '0;
      i_resetn = 1'b0;
      repeat (16) @(posedge i_clk);
      i_resetn <= 1'b1;
      // Register reset values, refusals and write-back
      apb(1'b0, eld_pkg::ADDR_CTRL, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, eld_pkg::ADDR_WAKE, 32'h0);
      chk(q, 32'h0000_0400);
      apb(1'b0, eld_pkg::ADDR_STAT, 32'h0);
      chk(q, 32'h0);
      apb(1'b1, 8'h0c, 32'hffff_ffff);
      chk(32'(e), 32'h1);
      apb(1'b1, eld_pkg::ADDR_STAT, 32'hffff_ffff);
      apb(1'b0, eld_pkg::ADDR_STAT, 32'h0);
      chk(q, 32'h0);
      apb(1'b1, eld_pkg::ADDR_WAKE, 32'h0000_0028);
      apb(1'b0, eld_pkg::ADDR_WAKE, 32'h0);
      chk(q, 32'h0000_0028);
      // Plain pass-through both ways
      txd   <= 8'hc3;
      tx_en <= 1'b1;
      tx_er <= 1'b1;
      rxd   <= 8'ha5;
      rx_dv <= 1'b1;
      repeat (2) @(posedge i_clk);
      chk(32'({x_en, x_er, x_txd}), 32'h3c3);
      chk(32'({m_dv, m_er, m_rxd}), 32'h2a5);
      // link up, fault free, settle time long past
      // Request during a frame, then idle
      txd     <= 8'h5a;
      tx_er   <= 1'b0;
      rx_dv   <= 1'b0;
      lpi_req <= 1'b1;
      repeat (2) @(posedge i_clk);
      chk(32'({x_en, x_er, x_txd}), 32'h25a);
      chk(32'(crs), 32'h1);
      tx_en <= 1'b0;
      txd   <= 8'h00;
      repeat (2) @(posedge i_clk);
      chk(32'({x_en, x_er, x_txd}), 32'(eld_pkg::LPI_DATA) | 32'h100);
      // Line sequence sleep, quiet, refresh, quiet
      wait_on(0, 3'd1, 4);
      wait_on(0, 3'd3, TS + 4);
      chk(32'(n >= TS), 32'h1);
      chk(32'(x_off), 32'h1);
      wait_on(0, 3'd4, TQ + 4);
      chk(32'(n >= TQ), 32'h1);
      wait_on(0, 3'd3, TR + 4);
      // Release: idle at once, wake, carrier held
      lpi_req <= 1'b0;
      repeat (2) @(posedge i_clk);
      chk(32'({x_en, x_er, x_txd}), 32'(eld_pkg::IDLE_DATA));
      chk(32'(crs), 32'h1);
      wait_on(0, 3'd5, 4);
      t = 2 + n;
      wait_on(0, 3'd0, TW + 4);
      chk(32'(n >= TW), 32'h1);
      t = t + n;
      wait_on(1, 3'd0, 60);
      chk(32'(t + n >= 40), 32'h1);
      // Gigabit mode waits for remote sleep
      apb(1'b1, eld_pkg::ADDR_CTRL, 32'h1);
      lpi_req <= 1'b1;
      wait_on(0, 3'd2, TS + 8);
      repeat (8) @(posedge i_clk);
      chk(32'(mode), 32'h2);
      chk(32'(x_off), 32'h0);
      chk(32'({x_en, x_er, x_txd}), 32'(eld_pkg::LPI_DATA) | 32'h100);
      slp <= 1'b1;
      @(posedge i_clk);
      slp <= 1'b0;
      wait_on(0, 3'd3, 8);
      // Receive low power idle and its end
      wait_on(2, 3'd1, 8);
      chk(32'({m_dv, m_er, m_rxd}), 32'(eld_pkg::IDLE_DATA));
      chk(32'(pwrdn), 32'h1);
      wak     <= 1'b1;
      lpi_req <= 1'b0;
      rxd     <= 8'h33;
      rx_dv   <= 1'b1;
      @(posedge i_clk);
      wak <= 1'b0;
      wait_on(2, 3'd0, 8);
      @(posedge i_clk);
      chk(32'({m_dv, m_er, m_rxd}), 32'h233);
      chk(32'(pwrdn), 32'h0);
      end_of_test;
   end
endmodule
